// ===== hdl/cmd_matcher.sv
`timescale 1ns/1ps
module cmd_matcher #(
   parameter int                LEN = 4,
   parameter logic [8*LEN-1:0]  PAT = '0
) (
   input  wire logic                      clk_sys,
   input  wire logic                      arst_n,
   input  wire fw_host_pkg::byte_stream_s rx,
   output logic                           hit
);
   import fw_host_pkg::*;

   logic [4:0] pos_reg;
   logic [4:0] pos_next;
   logic       hit_reg;
   logic       hit_next;

   // byte of the pattern at a position
   function automatic logic [7:0] pat_byte(input logic [4:0] p);
      pat_byte = PAT[8*(LEN-1-int'(p)) +: 8];
   endfunction

   // walk the pattern, restart on mismatch
   always_comb begin
      pos_next = pos_reg;
      hit_next = 1'b0;
      if (rx.valid) begin
         if (rx.data == pat_byte(pos_reg)) begin
            if (pos_reg == 5'(LEN-1)) begin
               hit_next = 1'b1;
               pos_next = 5'd0;
            end else begin
               pos_next = pos_reg + 5'd1;
            end
         end else begin
            pos_next = (rx.data == pat_byte(5'd0)) ? 5'd1 : 5'd0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pos_reg <= 5'd0;
         hit_reg <= 1'b0;
      end else begin
         pos_reg <= pos_next;
         hit_reg <= hit_next;
      end
   end

   assign hit = hit_reg;

endmodule

// ===== hdl/fw_host_pkg.sv
package fw_host_pkg;

   // clock and timing
   localparam int CLK_HZ          = 20_000_000;
   localparam int SLEEP_GUARD_MS  = 10;        // idle entry guard after decode
   localparam int WAKE_GUARD_MS   = 10;        // resume time after wake edge
   localparam int READY_PERIOD_MS = 1000;      // spacing of readiness characters

   // image store
   localparam int IMAGE_BYTES = 4096;
   localparam int BLOCK_BYTES = 128;
   localparam int PKT_LAST    = 131;           // block no, complement, data, crc hi, crc lo

   // transfer characters
   localparam logic [7:0] CH_SOH   = 8'h01;
   localparam logic [7:0] CH_EOT   = 8'h04;
   localparam logic [7:0] CH_ACK   = 8'h06;
   localparam logic [7:0] CH_NAK   = 8'h15;
   localparam logic [7:0] CH_READY = 8'h43;
   localparam logic [15:0] CRC_POLY = 16'h1021;

   // command byte patterns, first byte in the top bits
   localparam int SLEEP_LEN = 16;
   localparam logic [8*SLEEP_LEN-1:0] SLEEP_PAT = {8'h24, 8'h50, 8'h4f, 8'h50, 8'h57, 8'h52, 8'h2c, 8'h31,
                                                   8'h31, 8'h31, 8'h31, 8'h2a, 8'h36, 8'h36, 8'h0d, 8'h0a};
   localparam int RELOAD_TXT_LEN = 13;
   localparam logic [8*RELOAD_TXT_LEN-1:0] RELOAD_TXT_PAT = {8'h24, 8'h50, 8'h4f, 8'h50, 8'h52, 8'h4c, 8'h2c,
                                                             8'h52, 8'h2a, 8'h32, 8'h46, 8'h0d, 8'h0a};
   localparam int RELOAD_BIN_LEN = 12;
   localparam logic [8*RELOAD_BIN_LEN-1:0] RELOAD_BIN_PAT = {8'h10, 8'h01, 8'h52, 8'h45, 8'h4c, 8'h4f,
                                                             8'h41, 8'h44, 8'h5f, 8'h52, 8'h10, 8'h03};

   // states, gray along the sleep and wake path
   typedef enum logic [3:0] {
      ST_NORMAL     = 4'h0,
      ST_SLEEP_WAIT = 4'h1,
      ST_SLEEP      = 4'h3,
      ST_WAKE       = 4'h2,
      ST_PROG_WAIT  = 4'h6,
      ST_PROG_RX    = 4'h7,
      ST_PROG_ANS   = 4'h5,
      ST_STORE      = 4'h4,
      ST_RESTART    = 4'hc
   } ctrl_state_e;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } byte_stream_s;

   typedef struct packed {
      logic        valid;
      logic [11:0] addr;
      logic [7:0]  data;
   } flash_wr_s;

endpackage

// ===== hdl/host_cmd_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - sleep sentence 1111 idles core and amplifier
// - wait at least 10 ms before idle
// - receive line falling edge wakes device
// - ignore commands for 10 ms after wake
// - accept text reload sentence with checksum 2F
// - accept binary reload frame RELOAD_R
// - reload enters programming, sends character C
// - write flash after whole image, then restart
module host_cmd_ctrl #(
   parameter int SLEEP_CYC = fw_host_pkg::SLEEP_GUARD_MS * (fw_host_pkg::CLK_HZ / 1000),
   parameter int WAKE_CYC  = fw_host_pkg::WAKE_GUARD_MS * (fw_host_pkg::CLK_HZ / 1000),
   parameter int READY_CYC = fw_host_pkg::READY_PERIOD_MS * (fw_host_pkg::CLK_HZ / 1000)
) (
   input  wire logic                      clk_sys,
   input  wire logic                      arst_n,
   input  wire logic                      rx_line,
   input  wire fw_host_pkg::byte_stream_s rx_byte,
   output fw_host_pkg::byte_stream_s      tx_byte,
   input  wire logic                      tx_ready,
   output fw_host_pkg::flash_wr_s         flash_wr,
   input  wire logic                      flash_ready,
   output logic                           core_idle,
   output logic                           lna_idle,
   output logic                           prog_mode,
   output logic                           restart
);
   import fw_host_pkg::*;

   ctrl_state_e  state_reg,   state_next;
   logic [24:0]  timer_reg,   timer_next;
   logic [7:0]   idx_reg,     idx_next;
   logic [7:0]   blk_reg,     blk_next;
   logic [7:0]   blknum_reg,  blknum_next;
   logic         cmpl_ok_reg, cmpl_ok_next;
   logic [15:0]  crc_reg,     crc_next;
   logic [15:0]  crc_rx_reg,  crc_rx_next;
   logic [12:0]  base_reg,    base_next;
   logic [12:0]  wr_addr_reg, wr_addr_next;
   logic         started_reg, started_next;
   logic         eot_reg,     eot_next;
   logic         rx_prev_reg;
   logic         idle_reg,    idle_next;
   logic         prog_reg,    prog_next;
   logic         restart_reg, restart_next;
   byte_stream_s tx_reg,      tx_next;
   flash_wr_s    flash_reg,   flash_next;

   logic [7:0]   image_mem [IMAGE_BYTES];
   logic [12:0]  mem_addr;
   logic         mem_we;
   byte_stream_s cmd_feed;
   logic         sleep_hit;
   logic         reload_txt_hit;
   logic         reload_bin_hit;
   logic         rx_fall;
   logic         pkt_good;

   // crc-16 ccitt over one byte, msb first
   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      crc_upd = r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // command recognisers

   assign cmd_feed.valid = rx_byte.valid && (state_reg == ST_NORMAL);
   assign cmd_feed.data  = rx_byte.data;

   cmd_matcher #(.LEN(SLEEP_LEN), .PAT(SLEEP_PAT)) u_sleep (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .rx      (cmd_feed),
      .hit     (sleep_hit)
   );

   cmd_matcher #(.LEN(RELOAD_TXT_LEN), .PAT(RELOAD_TXT_PAT)) u_reload_txt (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .rx      (cmd_feed),
      .hit     (reload_txt_hit)
   );

   cmd_matcher #(.LEN(RELOAD_BIN_LEN), .PAT(RELOAD_BIN_PAT)) u_reload_bin (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .rx      (cmd_feed),
      .hit     (reload_bin_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // control

   // wake edge on the receive line
   assign rx_fall  = rx_prev_reg && !rx_line;
   assign pkt_good = (blknum_reg == blk_reg) && cmpl_ok_reg && (crc_reg == crc_rx_reg)
                     && (base_reg <= 13'(IMAGE_BYTES - BLOCK_BYTES));
   assign mem_addr = base_reg + 13'(idx_reg) - 13'd2;
   assign mem_we   = (state_reg == ST_PROG_RX) && rx_byte.valid && (idx_reg >= 8'd2)
                     && (idx_reg <= 8'd129) && (mem_addr < 13'(IMAGE_BYTES));

   always_comb begin
      state_next   = state_reg;
      timer_next   = timer_reg;
      idx_next     = idx_reg;
      blk_next     = blk_reg;
      blknum_next  = blknum_reg;
      cmpl_ok_next = cmpl_ok_reg;
      crc_next     = crc_reg;
      crc_rx_next  = crc_rx_reg;
      base_next    = base_reg;
      wr_addr_next = wr_addr_reg;
      started_next = started_reg;
      eot_next     = eot_reg;
      restart_next = 1'b0;
      tx_next      = tx_reg;
      flash_next   = flash_reg;
      if (tx_reg.valid && tx_ready) begin
         tx_next.valid = 1'b0;
      end
      if (flash_reg.valid && flash_ready) begin
         flash_next.valid = 1'b0;
      end
      unique case (state_reg)
         ST_NORMAL: begin
            if (reload_txt_hit || reload_bin_hit) begin
               // enter programming, ready char at once
               state_next   = ST_PROG_WAIT;
               timer_next   = 25'd0;
               blk_next     = 8'd1;
               base_next    = 13'd0;
               started_next = 1'b0;
               eot_next     = 1'b0;
            end else if (sleep_hit) begin
               state_next = ST_SLEEP_WAIT;
               timer_next = 25'(SLEEP_CYC - 1);
            end
         end
         ST_SLEEP_WAIT: begin
            if (timer_reg == 25'd0) begin
               state_next = ST_SLEEP;
            end else begin
               timer_next = timer_reg - 25'd1;
            end
         end
         ST_SLEEP: begin
            if (rx_fall) begin
               state_next = ST_WAKE;
               timer_next = 25'(WAKE_CYC - 1);
            end
         end
         ST_WAKE: begin
            if (timer_reg == 25'd0) begin
               state_next = ST_NORMAL;
            end else begin
               timer_next = timer_reg - 25'd1;
            end
         end
         ST_PROG_WAIT: begin
            if (!started_reg) begin
               if (timer_reg == 25'd0) begin
                  if (!tx_reg.valid) begin
                     tx_next    = '{valid: 1'b1, data: CH_READY};
                     timer_next = 25'(READY_CYC - 1);
                  end
               end else begin
                  timer_next = timer_reg - 25'd1;
               end
            end
            if (rx_byte.valid && rx_byte.data == CH_SOH) begin
               state_next   = ST_PROG_RX;
               started_next = 1'b1;
               idx_next     = 8'd0;
               crc_next     = 16'h0000;
            end else if (rx_byte.valid && rx_byte.data == CH_EOT && started_reg) begin
               state_next = ST_PROG_ANS;
               eot_next   = 1'b1;
            end
         end
         ST_PROG_RX: begin
            if (rx_byte.valid) begin
               idx_next = idx_reg + 8'd1;
               if (idx_reg == 8'd0) begin
                  blknum_next = rx_byte.data;
               end else if (idx_reg == 8'd1) begin
                  cmpl_ok_next = (rx_byte.data == ~blknum_reg);
               end else if (idx_reg <= 8'd129) begin
                  crc_next = crc_upd(crc_reg, rx_byte.data);
               end else if (idx_reg == 8'd130) begin
                  crc_rx_next[15:8] = rx_byte.data;
               end else begin
                  crc_rx_next[7:0] = rx_byte.data;
               end
               if (idx_reg == 8'(PKT_LAST)) begin
                  state_next = ST_PROG_ANS;
               end
            end
         end
         ST_PROG_ANS: begin
            if (!tx_reg.valid) begin
               if (eot_reg) begin
                  tx_next      = '{valid: 1'b1, data: CH_ACK};
                  state_next   = ST_STORE;
                  wr_addr_next = 13'd0;
               end else if (pkt_good) begin
                  tx_next    = '{valid: 1'b1, data: CH_ACK};
                  base_next  = base_reg + 13'(BLOCK_BYTES);
                  blk_next   = blk_reg + 8'd1;
                  state_next = ST_PROG_WAIT;
               end else begin
                  // repeated block is acknowledged, not stored
                  tx_next.valid = 1'b1;
                  tx_next.data  = ((blknum_reg == blk_reg - 8'd1) && cmpl_ok_reg) ? CH_ACK : CH_NAK;
                  state_next    = ST_PROG_WAIT;
               end
            end
         end
         ST_STORE: begin
            // flash write only after whole image
            if (!flash_reg.valid || flash_ready) begin
               if (wr_addr_reg == base_reg) begin
                  if (!tx_reg.valid) begin
                     state_next   = ST_RESTART;
                     restart_next = 1'b1;
                  end
               end else begin
                  flash_next   = '{valid: 1'b1, addr: wr_addr_reg[11:0], data: image_mem[wr_addr_reg[11:0]]};
                  wr_addr_next = wr_addr_reg + 13'd1;
               end
            end
         end
         ST_RESTART: begin
            state_next = ST_NORMAL;
         end
         default: begin
            state_next = ST_NORMAL;
         end
      endcase
      idle_next = (state_next == ST_SLEEP);
      prog_next = (state_next == ST_PROG_WAIT) || (state_next == ST_PROG_RX)
                  || (state_next == ST_PROG_ANS) || (state_next == ST_STORE);
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg   <= ST_NORMAL;
         timer_reg   <= 25'd0;
         idx_reg     <= 8'd0;
         blk_reg     <= 8'd1;
         blknum_reg  <= 8'd0;
         cmpl_ok_reg <= 1'b0;
         crc_reg     <= 16'h0000;
         crc_rx_reg  <= 16'h0000;
         base_reg    <= 13'd0;
         wr_addr_reg <= 13'd0;
         started_reg <= 1'b0;
         eot_reg     <= 1'b0;
         rx_prev_reg <= 1'b1;
         idle_reg    <= 1'b0;
         prog_reg    <= 1'b0;
         restart_reg <= 1'b0;
         tx_reg      <= '0;
         flash_reg   <= '0;
      end else begin
         state_reg   <= state_next;
         timer_reg   <= timer_next;
         idx_reg     <= idx_next;
         blk_reg     <= blk_next;
         blknum_reg  <= blknum_next;
         cmpl_ok_reg <= cmpl_ok_next;
         crc_reg     <= crc_next;
         crc_rx_reg  <= crc_rx_next;
         base_reg    <= base_next;
         wr_addr_reg <= wr_addr_next;
         started_reg <= started_next;
         eot_reg     <= eot_next;
         rx_prev_reg <= rx_line;
         idle_reg    <= idle_next;
         prog_reg    <= prog_next;
         restart_reg <= restart_next;
         tx_reg      <= tx_next;
         flash_reg   <= flash_next;
      end
   end

   // image buffer, no reset
   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         image_mem[mem_addr[11:0]] <= rx_byte.data;
      end
   end

   assign core_idle = idle_reg;
   assign lna_idle  = idle_reg;
   assign prog_mode = prog_reg;
   assign restart   = restart_reg;
   assign tx_byte   = tx_reg;
   assign flash_wr  = flash_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence s_reload_seen;
      (state_reg == ST_NORMAL) && (reload_txt_hit || reload_bin_hit);
   endsequence
   sequence s_ready_out;
      tx_byte.valid && (tx_byte.data == CH_READY) && prog_mode;
   endsequence

   property p_sleep_entry;
      (state_reg == ST_NORMAL) && sleep_hit && !reload_txt_hit && !reload_bin_hit
         |=> (state_reg == ST_SLEEP_WAIT) && (timer_reg == 25'(SLEEP_CYC - 1)) && !core_idle;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep sentence not taken");

   property p_sleep_delay;
      $rose(core_idle) |-> $past(state_reg) == ST_SLEEP_WAIT && $past(timer_reg) == 25'd0;
   endproperty
   a_sleep_delay: assert property (p_sleep_delay) else $error("idle entered before guard");

   property p_idle_pair;
      core_idle == lna_idle && core_idle == (state_reg == ST_SLEEP);
   endproperty
   a_idle_pair: assert property (p_idle_pair) else $error("idle outputs disagree with state");

   property p_wake;
      (state_reg == ST_SLEEP) && rx_fall |=> (state_reg == ST_WAKE) && (timer_reg == 25'(WAKE_CYC - 1)) ##1 !core_idle;
   endproperty
   a_wake: assert property (p_wake) else $error("falling edge did not wake");

   property p_wake_ignore;
      (state_reg == ST_WAKE) |-> !cmd_feed.valid && !sleep_hit && !reload_txt_hit && !reload_bin_hit
         ##1 (state_reg inside {ST_WAKE, ST_NORMAL});
   endproperty
   a_wake_ignore: assert property (p_wake_ignore) else $error("command decoded during wake guard");

   property p_reload;
      s_reload_seen |=> (state_reg == ST_PROG_WAIT) ##[1:3] s_ready_out;
   endproperty
   a_reload: assert property (p_reload) else $error("reload did not produce ready char");

   property p_flash_late;
      flash_wr.valid |-> prog_mode && eot_reg && started_reg;
   endproperty
   a_flash_late: assert property (p_flash_late) else $error("flash written before image complete");

   property p_restart;
      restart |-> !prog_mode && $past(state_reg) == ST_STORE && $past(wr_addr_reg) == $past(base_reg) ##1 !restart;
   endproperty
   a_restart: assert property (p_restart) else $error("restart out of order");

endmodule

// ===== test/host_cmd_ctrl_tb_top.sv
`timescale 1ns/1ps
module host_cmd_ctrl_tb_top;
   import fw_host_pkg::*;

   localparam int S_CYC = 20;
   localparam int W_CYC = 60;
   localparam int R_CYC = 50;

   logic         clk_sys;
   logic         arst_n;
   logic         rx_line;
   byte_stream_s rx_byte;
   byte_stream_s tx_byte;
   logic         tx_ready;
   flash_wr_s    flash_wr;
   logic         flash_ready = 1'b0;
   logic         core_idle;
   logic         lna_idle;
   logic         prog_mode;
   logic         restart;
   int           err_total   = 0;
   int           comparisons = 0;
   int           wr_count    = 0;
   int           rst_count   = 0;
   int           fcyc        = 0;
   logic         store_ok    = 1'b0;

   // clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   host_cmd_ctrl #(.SLEEP_CYC(S_CYC), .WAKE_CYC(W_CYC), .READY_CYC(R_CYC)) i_dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .rx_line(rx_line), .rx_byte(rx_byte),
      .tx_byte(tx_byte), .tx_ready(tx_ready), .flash_wr(flash_wr), .flash_ready(flash_ready),
      .core_idle(core_idle), .lna_idle(lna_idle), .prog_mode(prog_mode), .restart(restart)
   );

   host_model i_host (
      .clk_sys(clk_sys), .rx_line(rx_line), .rx_byte(rx_byte), .tx_byte(tx_byte), .tx_ready(tx_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic tx_expect(input string what, input logic [7:0] exp);
      logic [7:0] b;
      logic       ok;
      i_host.get_tx(b, ok);
      if (!ok) begin
         err_total++;
         $display("unexpected %s: expected %h, seen no byte", what, exp);
         conclude();
      end else begin
         check(what, 32'(b), 32'(exp));
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // flash accepts every third cycle
   always @(negedge clk_sys) begin
      fcyc <= fcyc + 1;
      flash_ready <= (fcyc % 3 == 0);
   end

   // watch flash writes and restart pulses
   always @(posedge clk_sys) begin
      if (arst_n && flash_wr.valid === 1'b1 && flash_ready) begin
         check("store_after_eot", 32'(store_ok), 32'h1);
         check("flash_data", 32'(flash_wr.data), 32'(i_host.img(int'(flash_wr.addr))));
         wr_count++;
      end
      if (restart === 1'b1) rst_count++;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check("core_idle_rst", 32'(core_idle), 32'h0);
      check("lna_idle_rst", 32'(lna_idle), 32'h0);
      check("prog_rst", 32'(prog_mode), 32'h0);
      check("tx_rst", 32'(tx_byte), 32'h0);
      check("flash_rst", 32'(flash_wr), 32'h0);
   endtask

   // stray start byte, sleep, wake, command in guard dropped
   task automatic t_sleep_wake();
      i_host.send_byte(8'h24);
      i_host.send_pat(128'(SLEEP_PAT), SLEEP_LEN);
      repeat (S_CYC) @(negedge clk_sys);
      check("idle_early", 32'(core_idle), 32'h0);
      @(negedge clk_sys);
      check("core_idle", 32'(core_idle), 32'h1);
      check("lna_idle", 32'(lna_idle), 32'h1);
      i_host.send_byte(8'h24);
      repeat (2) @(negedge clk_sys);
      check("woken", 32'(core_idle), 32'h0);
      i_host.send_pat(128'(RELOAD_TXT_PAT), RELOAD_TXT_LEN);
      repeat (3) @(negedge clk_sys);
      check("guard_drop", 32'(prog_mode), 32'h0);
      // host waits out the wake guard
      repeat (W_CYC) @(negedge clk_sys);
   endtask

   // reload, blocks, end of transfer, store and restart
   task automatic t_update(input logic text);
      int n;
      int r0;
      int len;
      len = text ? 256 : 128;
      r0 = rst_count;
      wr_count = 0;
      store_ok = 1'b0;
      if (text) i_host.send_pat(128'(RELOAD_TXT_PAT), RELOAD_TXT_LEN);
      else i_host.send_pat(128'(RELOAD_BIN_PAT), RELOAD_BIN_LEN);
      check("prog_early", 32'(prog_mode), 32'h0);
      @(negedge clk_sys);
      check("prog_mode", 32'(prog_mode), 32'h1);
      tx_expect("ready_char", CH_READY);
      i_host.stall = 3;
      if (text) tx_expect("ready_again", CH_READY);
      i_host.send_block(8'h01, 1'b0);
      tx_expect("ack_blk1", CH_ACK);
      if (text) begin
         i_host.send_block(8'h02, 1'b1);
         tx_expect("nak_bad_crc", CH_NAK);
         i_host.send_block(8'h02, 1'b0);
         tx_expect("ack_blk2", CH_ACK);
         i_host.send_block(8'h02, 1'b0);
         tx_expect("ack_dup", CH_ACK);
      end
      check("no_early_write", 32'(wr_count), 32'h0);
      store_ok = 1'b1;
      i_host.send_byte(CH_EOT);
      tx_expect("ack_eot", CH_ACK);
      i_host.stall = 0;
      for (n = 0; n < 3000 && rst_count == r0; n++) @(negedge clk_sys);
      if (rst_count == r0) begin
         err_total++;
         $display("unexpected restart: expected pulse, seen none");
         conclude();
      end else begin
         repeat (3) @(negedge clk_sys);
         check("write_count", 32'(wr_count), 32'(len));
         check("one_restart", 32'(rst_count - r0), 32'h1);
         check("prog_done", 32'(prog_mode), 32'h0);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   // reset stays released through both updates
   initial begin
      arst_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      arst_n = 1'b1;
      t_reset();
      t_sleep_wake();
      t_update(1'b1);
      t_update(1'b0);
      conclude();
   end
endmodule

// ===== test/host_model.sv
`timescale 1ns/1ps
module host_model (
   input  wire logic                      clk_sys,
   output logic                           rx_line,
   output fw_host_pkg::byte_stream_s      rx_byte,
   input  wire fw_host_pkg::byte_stream_s tx_byte,
   output logic                           tx_ready
);
   import fw_host_pkg::*;

   int stall = 0;  // cycles to hold off before taking a sent byte

   // idle line high, no byte offered
   initial begin
      rx_line  = 1'b1;
      rx_byte  = '0;
      tx_ready = 1'b0;
   end

   // image content at a byte address
   function automatic logic [7:0] img(input int a);
      return 8'(a) ^ 8'(a >> 8) ^ 8'h5a;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // one byte: start bit low, then a one-cycle valid pulse
   // three cycles a byte, far above the minimum rate
   task automatic send_byte(input logic [7:0] b);
      @(negedge clk_sys);
      rx_line = 1'b0;
      @(negedge clk_sys);
      rx_line = 1'b1;
      rx_byte = '{valid: 1'b1, data: b};
      @(negedge clk_sys);
      rx_byte = '{valid: 1'b0, data: ~b};  // stale data never repeats
   endtask

   // lowest n bytes of p, first byte highest
   task automatic send_pat(input logic [127:0] p, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         send_byte(p[8*(n-1-i) +: 8]);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // one crc block; bad flips the crc
   task automatic send_block(input logic [7:0] n, input logic bad);
      logic [15:0] crc;
      logic [7:0]  d;
      int          i;
      int          k;
      crc = 16'h0000;
      send_byte(CH_SOH);
      send_byte(n);
      send_byte(~n);
      for (i = 0; i < 128; i++) begin
         d = img((int'(n) - 1) * 128 + i);
         crc = crc ^ {d, 8'h00};
         for (k = 0; k < 8; k++) begin
            crc = crc[15] ? ((crc << 1) ^ CRC_POLY) : (crc << 1);
         end
         send_byte(d);
      end
      send_byte(crc[15:8] ^ {7'h00, bad});
      send_byte(crc[7:0]);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // take one sent byte, slowly when stall is set
   task automatic get_tx(output logic [7:0] b, output logic ok);
      int n;
      ok = 1'b0;
      b  = '0;
      for (n = 0; n < 200 && !ok; n++) begin
         @(negedge clk_sys);
         ok = (tx_byte.valid === 1'b1);
      end
      if (ok) begin
         repeat (stall) @(negedge clk_sys);
         // data stands while valid waits for ready
         b = tx_byte.data;
         tx_ready = 1'b1;
         @(posedge clk_sys);
         @(negedge clk_sys);
         tx_ready = 1'b0;
      end
   endtask
endmodule
